//--- include/chs_pkg.sv
// constants and types for the card host select and write strobe controller
package chs_pkg;
  // byte lane selection codes, active-low enables as {high, low}
  localparam logic [1:0] CHS_EN_NONE  = 2'h3;
  localparam logic [1:0] CHS_EN_WORD  = 2'h0;
  localparam logic [1:0] CHS_EN_LOWLN = 2'h2;
  localparam logic [1:0] CHS_EN_HIGH  = 2'h1;
  // data widths and buffer shape
  localparam int CHS_WORD_W   = 16;
  localparam int CHS_BYTE_W   = 8;
  localparam int CHS_FIFO_DEP = 32;
  // link strobe divider: half period of the link clock in system cycles
  localparam logic [3:0] CHS_STROBE_DIV = 4'h1;
  // reset values
  localparam logic [15:0] CHS_DATA_RST = 16'h0000;
  // access kinds on the command port
  typedef enum logic [2:0]
  {
    CHS_KIND_WORD  = 3'h1,
    CHS_KIND_BYTE  = 3'h2,
    CHS_KIND_HIGH  = 3'h4
  } chs_kind_t;
  // host controller state
  typedef enum logic [4:0]
  {
    CHS_IDLE  = 5'h01,
    CHS_PIO   = 5'h02,
    CHS_BURST = 5'h04,
    CHS_PAUSE = 5'h08,
    CHS_STOP  = 5'h10
  } chs_state_t;
endpackage

//--- src/chs_fifo.sv
// parameterised valid/ready fifo for outgoing burst words
`timescale 1ns/1ns
module chs_fifo
  import chs_pkg::*;
#(
  parameter int WIDTH = CHS_WORD_W,
  parameter int DEPTH = CHS_FIFO_DEP
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // write side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic [WIDTH-1:0] rd_data_r;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  // honest full and empty from pointer compare
  always_comb
  begin
    full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    empty    = (wp_r == rp_r);
    wr_ready = !full;
    rd_valid = !empty;
    do_wr    = wr_valid && !full;
    do_rd    = rd_ready && !empty;
    wp_nxt   = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt   = do_rd ? rp_r + 1'b1 : rp_r;
    rd_data  = rd_data_r;
  end

  // pointers, storage, registered head word
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (do_wr)
      mem_r[wp_r[AW-1:0]] <= wr_data;
    // write into the head slot bypasses the array, else head word would be stale
    if (do_wr && (wp_r[AW-1:0] == rp_nxt[AW-1:0]))
      rd_data_r <= wr_data;
    else
      rd_data_r <= mem_r[rp_nxt[AW-1:0]];
  end
endmodule // chs_fifo

//--- src/chs_host.sv
// host controller for the card socket: lane select, chip selects, write burst strobe
`timescale 1ns/1ns
// Overview of operation
// - host pauses a burst by holding the strobe still when no data
// - card counts as inserted only with both detect lines low
// - during dma acknowledge both selects stay negated, transfers sixteen bits
// - drive role strap driven low, never left floating
module chs_host
  import chs_pkg::*;
(
  // system clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // link clock: strobe edges are launched on this domain
  input  wire logic        link_clock,
  // pio command port
  input  wire logic        pio_req,
  input  wire chs_kind_t   pio_kind,
  input  wire logic        pio_addr0,
  input  wire logic        pio_ide,
  input  wire logic        pio_ctrl,
  input  wire logic [15:0] pio_wdata,
  output logic             pio_busy,
  // burst command port
  input  wire logic        burst_start,
  input  wire logic        burst_stop,
  input  wire logic        burst_valid,
  output logic             burst_ready,
  input  wire logic [15:0] burst_data,
  output logic             burst_active,
  // card detect inputs and status
  input  wire logic        card_detect_one,
  input  wire logic        card_detect_two,
  output logic             card_present,
  // card side pins
  output logic             low_byte_enable,
  output logic             high_byte_enable,
  output logic             address_bit_zero,
  output logic             command_block_select,
  output logic             control_block_select,
  output logic             dma_acknowledge_n,
  output logic             io_write_strobe,
  output logic             drive_role_strap,
  output logic             host_data_strobe,
  output logic [15:0]      data_out,
  output logic             data_oe
);
  chs_state_t  st_r;
  chs_state_t  st_nxt;
  logic [1:0]  en_r;
  logic [1:0]  en_nxt;
  logic        a0_r;
  logic        a0_nxt;
  logic [1:0]  cs_r;
  logic [1:0]  cs_nxt;
  logic [15:0] pd_r;
  logic [15:0] pd_nxt;
  logic [1:0]  cd_s1_r;
  logic [1:0]  cd_s2_r;
  logic        f_valid;
  logic        f_ready;
  logic [15:0] f_data;
  logic        req_tg_r;
  logic        req_tg_nxt;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic [15:0] word_r;
  logic [15:0] word_nxt;
  logic        pend_r;
  logic        pend_nxt;
  // link domain
  logic        lreq_s1_r;
  logic        lreq_s2_r;
  logic        lreq_s3_r;
  logic        lack_r;
  logic        lack_nxt;
  logic        lstb_r;
  logic        lstb_nxt;
  logic [15:0] ldat_r;
  logic [15:0] ldat_nxt;
  logic        lreq_new;

  ////////////////////////////////////////////////////////////////////////////
  // outgoing burst words buffered ahead of the link
  chs_fifo #(.WIDTH(CHS_WORD_W), .DEPTH(CHS_FIFO_DEP)) u_fifo
  (
    .clock    (clock),
    .srst     (srst),
    .wr_valid (burst_valid && burst_active),
    .wr_ready (f_ready),
    .wr_data  (burst_data),
    .rd_valid (f_valid),
    .rd_ready (!pend_r && (st_r == CHS_BURST || st_r == CHS_PAUSE) && f_valid),
    .rd_data  (f_data)
  );
  assign burst_ready = f_ready && burst_active;

  ////////////////////////////////////////////////////////////////////////////
  // card detect synchroniser and presence
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cd_s1_r <= 2'h3;
      cd_s2_r <= 2'h3;
    end
    else
    begin
      cd_s1_r <= {card_detect_two, card_detect_one};
      cd_s2_r <= cd_s1_r;
    end
  end
  assign card_present = (cd_s2_r == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // access state, lane decode and handoff to link
  always_comb
  begin
    st_nxt     = st_r;
    en_nxt     = en_r;
    a0_nxt     = a0_r;
    cs_nxt     = cs_r;
    pd_nxt     = pd_r;
    req_tg_nxt = req_tg_r;
    word_nxt   = word_r;
    pend_nxt   = pend_r;
    case (st_r)
      CHS_IDLE:
      begin
        en_nxt = CHS_EN_NONE;
        cs_nxt = 2'h3;
        if (burst_start && card_present)
        begin
          cs_nxt = 2'h3;
          st_nxt = CHS_BURST;
        end
        else if (pio_req && card_present)
        begin
          pd_nxt = pio_wdata;
          a0_nxt = pio_addr0;
          if (pio_ide)
            cs_nxt = pio_ctrl ? 2'h1 : 2'h2;
          else if (pio_kind == CHS_KIND_WORD)
          begin
            en_nxt = CHS_EN_WORD;
            a0_nxt = 1'b0;
          end
          else if (pio_kind == CHS_KIND_HIGH)
            en_nxt = CHS_EN_HIGH;
          else
            en_nxt = CHS_EN_LOWLN;
          st_nxt = CHS_PIO;
        end
      end
      CHS_PIO:
      begin
        en_nxt = CHS_EN_NONE;
        cs_nxt = 2'h3;
        st_nxt = CHS_IDLE;
      end
      CHS_BURST, CHS_PAUSE:
      begin
        if (pend_r && (ack_s2_r == req_tg_r))
          pend_nxt = 1'b0;
        if (!pend_r && f_valid)
        begin
          word_nxt   = f_data;
          req_tg_nxt = !req_tg_r;
          pend_nxt   = 1'b1;
        end
        st_nxt = f_valid || pend_r ? CHS_BURST : CHS_PAUSE;
        if (burst_stop && !pend_r && !f_valid)
          st_nxt = CHS_STOP;
      end
      CHS_STOP:
        st_nxt = CHS_IDLE;
      default:
        st_nxt = CHS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r     <= CHS_IDLE;
      en_r     <= CHS_EN_NONE;
      a0_r     <= 1'b0;
      cs_r     <= 2'h3;
      pd_r     <= CHS_DATA_RST;
      req_tg_r <= 1'b0;
      word_r   <= CHS_DATA_RST;
      pend_r   <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      en_r     <= en_nxt;
      a0_r     <= a0_nxt;
      cs_r     <= cs_nxt;
      pd_r     <= pd_nxt;
      req_tg_r <= req_tg_nxt;
      word_r   <= word_nxt;
      pend_r   <= pend_nxt;
      ack_s1_r <= lack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: one strobe edge per handed-over word
  assign lreq_new = (lreq_s2_r != lreq_s3_r);
  always_comb
  begin
    lack_nxt = lack_r;
    lstb_nxt = lstb_r;
    ldat_nxt = ldat_r;
    if (lreq_new)
    begin
      ldat_nxt = word_r; // stable while request pending
      lstb_nxt = !lstb_r;
      lack_nxt = lreq_s2_r;
    end
  end

  always_ff @(posedge link_clock)
  begin
    if (srst)
    begin
      lreq_s1_r <= 1'b0;
      lreq_s2_r <= 1'b0;
      lreq_s3_r <= 1'b0;
      lack_r    <= 1'b0;
      lstb_r    <= 1'b0;
      ldat_r    <= CHS_DATA_RST;
    end
    else
    begin
      lreq_s1_r <= req_tg_r;
      lreq_s2_r <= lreq_s1_r;
      lreq_s3_r <= lreq_s2_r;
      lack_r    <= lack_nxt;
      lstb_r    <= lstb_nxt;
      ldat_r    <= ldat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_comb
  begin
    burst_active         = (st_r == CHS_BURST) || (st_r == CHS_PAUSE);
    pio_busy             = (st_r != CHS_IDLE);
    low_byte_enable      = en_r[0];
    high_byte_enable     = en_r[1];
    address_bit_zero     = a0_r;
    command_block_select = burst_active ? 1'b1 : cs_r[0];
    control_block_select = burst_active ? 1'b1 : cs_r[1];
    dma_acknowledge_n    = !burst_active;
    io_write_strobe      = (st_r == CHS_STOP);
    drive_role_strap     = 1'b0;
    host_data_strobe     = lstb_r;
    data_out             = burst_active ? ldat_r : pd_r;
    data_oe              = (st_r == CHS_PIO) || burst_active;
  end
endmodule // chs_host

//--- testbench/chs_card_model.sv
// card model: detect pins, lane decode, burst word capture
`timescale 1ns/1ns
module chs_card_model
  import chs_pkg::*;
(
  // socket and host pins
  input  logic        inserted,
  input  logic        low_byte_enable,
  input  logic        high_byte_enable,
  input  logic        address_bit_zero,
  input  logic        command_block_select,
  input  logic        control_block_select,
  input  logic        dma_acknowledge_n,
  input  logic        io_write_strobe,
  input  logic        host_data_strobe,
  input  logic [15:0] data_out,
  // detect pins, pulled up while out
  output logic        card_detect_one,
  output logic        card_detect_two
);
  logic [15:0] rx_q[$], lane_seen;
  logic [1:0]  en_seen, cs_seen;
  logic        a0_seen, stopped = 1'b0;
  int          n_acc = 0;
  // detect pins grounded while the card is inserted
  assign card_detect_one = !inserted;
  assign card_detect_two = !inserted;
  // snapshot of one access once its pins settle
  always @(negedge low_byte_enable or negedge high_byte_enable
    or negedge command_block_select or negedge control_block_select)
  begin
    #1;
    n_acc++;
    en_seen = {high_byte_enable, low_byte_enable};
    cs_seen = {control_block_select, command_block_select};
    a0_seen = address_bit_zero;
    lane_seen = en_seen == CHS_EN_WORD ? data_out :
      en_seen == CHS_EN_HIGH ? data_out & 16'hFF00 : data_out & 16'h00FF;
  end
  // one word per strobe edge; a quiet strobe is only a pause
  always @(host_data_strobe)
  begin
    #1;
    if (!dma_acknowledge_n && !stopped)
      rx_q.push_back(data_out);
  end
  // stop on the io write line ends the burst
  always @(posedge io_write_strobe or negedge dma_acknowledge_n)
    stopped = io_write_strobe;
endmodule // chs_card_model

//--- testbench/chs_host_chk.sv
// checker of the host controller pin behaviour
`timescale 1ns/1ns
module chs_host_chk
  import chs_pkg::*;
(
  // commands
  input logic      clock,
  input logic      srst,
  input logic      pio_req,
  input chs_kind_t pio_kind,
  input logic      pio_ide,
  input logic      pio_ctrl,
  input logic      pio_busy,
  // card pins
  input logic      card_detect_one,
  input logic      card_detect_two,
  input logic      card_present,
  input logic      low_byte_enable,
  input logic      high_byte_enable,
  input logic      address_bit_zero,
  input logic      command_block_select,
  input logic      control_block_select,
  input logic      dma_acknowledge_n,
  input logic      drive_role_strap,
  input logic      io_write_strobe,
  input logic      data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // pio command taken in idle with the card in
  logic take;
  assign take = pio_req && !pio_busy && card_present;
  ////////////////////////////////////////////////////////////////
  strap_low_a: assert property (!drive_role_strap) else $error("strap high");
  dma_sel_a: assert property (!dma_acknowledge_n |->
    command_block_select && control_block_select) else $error("select during dma");
  detect_a: assert property ((card_detect_one || card_detect_two) [*4] |-> !card_present)
    else $error("present with detect high");
  word_a: assert property (take && !pio_ide && pio_kind == CHS_KIND_WORD |=>
    {high_byte_enable, low_byte_enable} == CHS_EN_WORD && !address_bit_zero ##1 !pio_busy)
    else $error("word access");
  sel_a: assert property (take && pio_ide |=>
    command_block_select == $past(pio_ctrl) && control_block_select != $past(pio_ctrl))
    else $error("select decode");
  oe_burst_a: assert property (!dma_acknowledge_n |-> data_oe)
    else $error("data bus not driven in burst");
  stop_pulse_a: assert property (io_write_strobe |=>
    !io_write_strobe && dma_acknowledge_n) else $error("stop not one cycle");
endmodule // chs_host_chk
////////////////////////////////////////////////////////////////
// attach beside every host controller
bind chs_host chs_host_chk chs_host_chk_inst (.*);

//--- testbench/test_card_host_select_and_write_strobe.sv
// self-checking bench for the card host controller
`timescale 1ns/1ns
module test_card_host_select_and_write_strobe;
  import chs_pkg::*;
  logic clock = 1'b0, srst = 1'b1, link_clock = 1'b0, inserted = 1'b1, took;
  logic pio_req = 1'b0, pio_addr0 = 1'b0, pio_ide = 1'b0, pio_ctrl = 1'b0;
  logic burst_start = 1'b0, burst_stop = 1'b0, burst_valid = 1'b0;
  logic pio_busy, burst_ready, burst_active, card_present, card_detect_one, card_detect_two;
  logic low_byte_enable, high_byte_enable, address_bit_zero, command_block_select;
  logic control_block_select, dma_acknowledge_n, io_write_strobe, drive_role_strap;
  logic host_data_strobe, data_oe;
  logic [15:0] pio_wdata = 16'h0000, burst_data = 16'h0000, data_out, exp_q[$];
  chs_kind_t pio_kind = CHS_KIND_WORD;
  int err_count = 0, n_tests = 0, cycles = 0, refused = 0, k, i;
  ////////////////////////////////////////////////////////////////
  // design, card, clocks and hang guard
  chs_host chs_host_inst (.*);
  chs_card_model chs_card_model_inst (.*);
  always #20 clock = ~clock;
  always #24 link_clock = ~link_clock;
  always @(posedge clock)
    if (++cycles == 6000)
      tally_and_finish(1);
  // one value comparison
  task automatic check(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts and verdict
  task automatic tally_and_finish(input int hang);
    err_count += hang;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one pio access, judged by what the card saw
  task automatic pio(input chs_kind_t kd, input logic a0, ide, ctl);
    int n0;
    logic [15:0] d, en, ln;
    n0 = chs_card_model_inst.n_acc;
    d = 16'($urandom);
    en = 16'(kd == CHS_KIND_WORD ? CHS_EN_WORD : kd == CHS_KIND_HIGH ? CHS_EN_HIGH : CHS_EN_LOWLN);
    ln = kd == CHS_KIND_WORD ? d : kd == CHS_KIND_HIGH ? d & 16'hFF00 : d & 16'h00FF;
    @(negedge clock);
    pio_kind = kd;
    pio_addr0 = a0;
    pio_ide = ide;
    pio_ctrl = ctl;
    pio_wdata = d;
    pio_req = 1'b1;
    @(negedge clock);
    pio_req = 1'b0;
    repeat (2) @(negedge clock);
    check("access", 16'(n0 + 1), 16'(chs_card_model_inst.n_acc));
    if (ide)
      check("selects", ctl ? 16'h0001 : 16'h0002, 16'(chs_card_model_inst.cs_seen));
    else
    begin
      check("enables", en, 16'(chs_card_model_inst.en_seen));
      check("lanes", ln, chs_card_model_inst.lane_seen);
      if (kd == CHS_KIND_BYTE)
        check("addr0", 16'(a0), 16'(chs_card_model_inst.a0_seen));
    end
  endtask
  // offer n random words to the fifo, counting refusals
  task automatic push(input int n);
    int got;
    got = 0;
    took = 1'b0;
    burst_data = 16'($urandom);
    for (int t = 0; t < 400 && got < n; t++)
    begin
      @(negedge clock);
      if (took)
        burst_data = 16'($urandom);
      burst_valid = 1'b1;
      #1;
      took = burst_ready === 1'b1;
      if (took)
      begin
        exp_q.push_back(burst_data);
        got++;
      end
      else
        refused++;
    end
    @(negedge clock);
    burst_valid = 1'b0;
  endtask
  // stimulus
  initial
  begin
    void'($urandom(32'hF202));
    repeat (12) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    for (i = 0; i < 2; i++)
    begin
      pio(CHS_KIND_WORD, 1'b0, 1'b0, 1'b0);
      pio(CHS_KIND_HIGH, 1'b1, 1'b0, 1'b0);
      pio(CHS_KIND_BYTE, i[0], 1'b0, 1'b0);
      pio(CHS_KIND_WORD, 1'b0, 1'b1, i[0]);
    end
    inserted = 1'b0;
    repeat (5) @(negedge clock);
    check("present", 16'h0000, 16'(card_present));
    k = chs_card_model_inst.n_acc;
    pio_req = 1'b1;
    repeat (3) @(negedge clock);
    pio_req = 1'b0;
    check("refused", 16'(k), 16'(chs_card_model_inst.n_acc));
    inserted = 1'b1;
    repeat (5) @(negedge clock);
    burst_start = 1'b1;
    @(negedge clock);
    burst_start = 1'b0;
    @(negedge clock);
    check("dma ack", 16'h0000, 16'(dma_acknowledge_n));
    push(60);
    check("full", 16'h0001, 16'(refused > 0));
    repeat (300) @(negedge clock);
    k = host_data_strobe;
    repeat (30) @(negedge clock);
    check("pause", 16'(k), 16'(host_data_strobe));
    push(5);
    burst_stop = 1'b1;
    for (i = 0; i < 500 && burst_active !== 1'b0; i++)
      @(negedge clock);
    burst_stop = 1'b0;
    check("stopped", 16'h0001, 16'(chs_card_model_inst.stopped));
    check("count", 16'(exp_q.size()), 16'(chs_card_model_inst.rx_q.size()));
    foreach (exp_q[j]) check("word", exp_q[j], chs_card_model_inst.rx_q[j]);
    tally_and_finish(0);
  end
endmodule // test_card_host_select_and_write_strobe
